//--- pkg/nand_feature_map.svh
// Offsets, field positions, reset values and opcodes of the feature
// registers. Assumes inclusion by bare name from pkg/ on the search path.
//
// Functional notes
// RULE1: Protect code zero leaves every block unlocked.
// RULE2: Select 0: codes 1..9 lock upper fractions.
// RULE3: Select 1: codes 1..9 lock lower fractions.
// RULE4: Codes 101x and 11xx lock whole array.
// RULE5: Program or erase into locked blocks ignored.
// RULE6: OTP, unique ID access only when enabled.
// RULE7: ECC enable bit steers internal ECC, default on.
// RULE8: OTP protect and enable bits select mode.
// RULE9: Freeze bit settable only with both guards set.
// RULE10: OTP enable and ECC enable are volatile.
// RULE11: Status byte readable at any time, even busy.
// RULE12: Program fail set on failure or locked target.
// RULE13: Program fail cleared by program start, reset.
// RULE14: Erase fail set on failure or locked target.
// RULE15: Erase fail cleared by erase start, reset.
// RULE16: Write enable latch gates program and erase.
// RULE17: Busy high while program, read, erase, reset.
// RULE18: ECC result cleared at reset, read start.
// RULE19: Host ignores ECC result when ECC disabled.
// RULE20: After power-up, ECC reflects boot page load.
// RULE21: ECC result: none, corrected, uncorrected, reserved.
// RULE22: Set and get feature opcodes, one address byte.
// RULE23: Write enable sets latch, write disable clears.
// RULE24: Reserved bits read zero, ignore writes.
`ifndef NAND_FEATURE_MAP_SVH
`define NAND_FEATURE_MAP_SVH

`define FA_PROTECT        8'hA0
`define FA_CONFIG         8'hB0
`define FA_STATUS         8'hC0

`define OPC_GET_FEATURE   8'h0F
`define OPC_SET_FEATURE   8'h1F
`define OPC_WRITE_ENABLE  8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_RESET         8'hFF

`define PR_RESET          8'h7C
`define CR_RESET          8'h10
`define SR_RESET          8'h00

`define PR_GUARD_A        7
`define PR_CODE_HI        6
`define PR_CODE_LO        3
`define PR_TOP_BOTTOM     2
`define PR_WP_ENABLE      1
`define PR_GUARD_B        0

`define CR_OTP_PROTECT    7
`define CR_OTP_ENABLE     6
`define CR_FREEZE         5
`define CR_ECC_ENABLE     4

`define SR_ECC_HIGH       5
`define SR_ECC_LOW        4
`define SR_PROG_FAIL      3
`define SR_ERASE_FAIL     2
`define SR_WEL            1
`define SR_BUSY           0

`define ECC_NONE          2'h0
`define ECC_CORRECTED     2'h1
`define ECC_UNCORRECTED   2'h2
`define ECC_RESERVED      2'h3

`define BLOCK_W           10
`define PROT_CODE_NONE    4'h0
`define PROT_CODE_MAX     4'h9

`endif

//--- pkg/nand_feature_pkg.sv
// Types shared by the feature register bank, its checker, engine model and bench.
// Assumes nand_feature_map.svh is reachable on the include path.
`default_nettype none

package nand_feature_pkg;
`include "nand_feature_map.svh"

    typedef enum logic [2:0] {
        OP_PROGRAM,
        OP_ERASE,
        OP_READ,
        OP_RESET,
        OP_BOOT
    } op_kind_t;

    typedef enum logic [1:0] {
        OTP_NORMAL,
        OTP_ACCESS,
        OTP_NOT_APPLICABLE,
        OTP_LOCKED
    } otp_mode_t;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_IDLE,
        ST_BUSY
    } ctrl_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] addr;
        logic [7:0] data;
    } feat_cmd_t;

    typedef struct packed {
        logic                valid;
        op_kind_t            kind;
        logic [`BLOCK_W-1:0] block;
        logic                addr_bad;
        logic                otp;
    } op_req_t;

    typedef struct packed {
        logic                valid;
        op_kind_t            kind;
        logic [`BLOCK_W-1:0] block;
        logic                otp;
        logic                ecc_on;
    } op_start_t;

    typedef struct packed {
        logic       valid;
        logic       fail;
        logic [1:0] ecc;
    } op_done_t;
endpackage

`default_nettype wire

//--- core/block_lock_decode.sv
// Decides whether one block lies in the region locked by the protect code.
// Assumes inputs are stable register fields and a request's block index.
`default_nettype none

`include "nand_feature_map.svh"

module block_lock_decode (
    // Protect fields
    input  wire logic [3:0]          protect_code,
    input  wire logic                top_bottom_select,
    // Block under test
    input  wire logic [`BLOCK_W-1:0] block,
    // Result
    output logic                     locked
);
    logic [`BLOCK_W-1:0] cmp_mask;
    logic                upper_hit;
    logic                lower_hit;
    logic                fraction_code;
    logic                whole_code;

    // Code n protects 2**n blocks: compare only index bits n and above
    genvar i;
    for (i = 0; i < `BLOCK_W; i++)
    begin : g_mask
        assign cmp_mask[i] = (protect_code <= 4'(i)); // RULE2
    end

    assign upper_hit     = &(block | ~cmp_mask); // RULE2
    assign lower_hit     = ~|(block & cmp_mask); // RULE3
    assign fraction_code = (protect_code != `PROT_CODE_NONE) &&
                           (protect_code <= `PROT_CODE_MAX); // RULE1
    assign whole_code    = (protect_code > `PROT_CODE_MAX); // RULE4
    assign locked        = whole_code ||
                           (fraction_code &&
                            (top_bottom_select ? lower_hit : upper_hit)); // RULE3
endmodule

`default_nettype wire

//--- core/nand_feature_protect_status_regs.sv
// Protection, configuration and status feature registers of the flash.
// Assumes SPI framing hands over whole command bytes on clk, and that the
// array engine answers each started operation with exactly one done.
`default_nettype none

`include "nand_feature_map.svh"

module nand_feature_protect_status_regs (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Feature and latch commands from SPI framing
    input  wire nand_feature_pkg::feat_cmd_t cmd,
    // Array operation requests from SPI framing
    input  wire nand_feature_pkg::op_req_t   op_req,
    // Feature read-back byte
    output logic [7:0]                       rd_data,
    output logic                             rd_valid,
    // Array engine
    output nand_feature_pkg::op_start_t      op_start,
    input  wire nand_feature_pkg::op_done_t  op_done,
    // Live state
    output logic                             ecc_enable,
    output nand_feature_pkg::otp_mode_t      otp_mode,
    output logic                             busy,
    output logic                             write_enable_latch,
    output logic                             protect_frozen
);
    import nand_feature_pkg::*;

    logic        rst_meta_q;
    logic        rst_sync_q;
    logic        rst_i_n;

    logic [7:0]  pr_q;
    logic [7:0]  pr_d;
    logic [7:0]  cr_q;
    logic [7:0]  cr_d;
    logic [7:0]  sr_view;

    ctrl_state_t state_q;
    ctrl_state_t state_d;
    op_kind_t    cur_kind_q;
    op_kind_t    cur_kind_d;

    logic        busy_q;
    logic        busy_d;
    logic        wel_q;
    logic        wel_d;
    logic        prog_fail_q;
    logic        prog_fail_d;
    logic        erase_fail_q;
    logic        erase_fail_d;
    logic [1:0]  ecc_result_q;
    logic [1:0]  ecc_result_d;

    logic [7:0]  rd_data_q;
    logic [7:0]  rd_data_d;
    logic        rd_valid_q;
    op_start_t   op_start_q;
    op_start_t   op_start_d;
    otp_mode_t   otp_mode_q;
    otp_mode_t   otp_mode_d;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_i_n = rst_sync_q;

    // Command decode
    logic is_get;
    logic is_set;
    logic is_wren;
    logic is_wrdis;
    logic is_reset;
    logic addr_pr;
    logic addr_cr;
    logic addr_sr;

    assign is_get   = cmd.valid && (cmd.opcode == `OPC_GET_FEATURE); // RULE22
    assign is_set   = cmd.valid && (cmd.opcode == `OPC_SET_FEATURE); // RULE22
    assign is_wren  = cmd.valid && (cmd.opcode == `OPC_WRITE_ENABLE);
    assign is_wrdis = cmd.valid && (cmd.opcode == `OPC_WRITE_DISABLE);
    assign is_reset = cmd.valid && (cmd.opcode == `OPC_RESET) &&
                      (state_q != ST_BOOT);
    assign addr_pr  = (cmd.addr == `FA_PROTECT);
    assign addr_cr  = (cmd.addr == `FA_CONFIG);
    assign addr_sr  = (cmd.addr == `FA_STATUS);

    // Protection register and its freeze
    logic guard_a;
    logic guard_b;
    logic pr_open;
    logic pr_write;
    logic cr_write;
    logic freeze_ok;

    assign guard_a   = pr_q[`PR_GUARD_A];
    assign guard_b   = pr_q[`PR_GUARD_B];
    // Guard b alone also blocks writes to the register until the next reset
    assign pr_open   = !cr_q[`CR_FREEZE] && !(guard_b && !guard_a); // RULE9
    assign pr_write  = is_set && addr_pr && pr_open;
    assign cr_write  = is_set && addr_cr;
    assign freeze_ok = guard_a && guard_b; // RULE9
    assign pr_d      = pr_write ? cmd.data : pr_q;

    // Configuration register next value
    logic [7:0] cr_wr_val;

    // OTP protect and freeze only ever set; the other two follow writes
    assign cr_wr_val[`CR_OTP_PROTECT] = cr_q[`CR_OTP_PROTECT] ||
                                        cmd.data[`CR_OTP_PROTECT];
    assign cr_wr_val[`CR_OTP_ENABLE]  = cmd.data[`CR_OTP_ENABLE]; // RULE10
    assign cr_wr_val[`CR_FREEZE]      = cr_q[`CR_FREEZE] ||
                                        (cmd.data[`CR_FREEZE] &&
                                         freeze_ok); // RULE9
    assign cr_wr_val[`CR_ECC_ENABLE]  = cmd.data[`CR_ECC_ENABLE]; // RULE10
    assign cr_wr_val[3:0]             = 4'h0; // RULE24
    assign cr_d = cr_write ? cr_wr_val : cr_q;

    // OTP mode from protect and enable pair
    logic [1:0] otp_pair;

    assign otp_pair   = {cr_d[`CR_OTP_PROTECT], cr_d[`CR_OTP_ENABLE]};
    assign otp_mode_d = (otp_pair == 2'h0) ? OTP_NORMAL :
                        (otp_pair == 2'h1) ? OTP_ACCESS :
                        (otp_pair == 2'h3) ? OTP_LOCKED :
                                             OTP_NOT_APPLICABLE; // RULE8

    logic otp_en;
    logic otp_lock;

    assign otp_en   = cr_q[`CR_OTP_ENABLE];
    assign otp_lock = (otp_mode_q == OTP_LOCKED);

    // Array request screening
    logic blk_locked;

    block_lock_decode u_lock (
        .protect_code      (pr_q[`PR_CODE_HI:`PR_CODE_LO]),
        .top_bottom_select (pr_q[`PR_TOP_BOTTOM]),
        .block             (op_req.block),
        .locked            (blk_locked)
    );

    logic req_live;
    logic req_prog;
    logic req_erase;
    logic req_read;
    logic otp_gate;
    logic prog_bad;
    logic erase_bad;

    // Requests while busy, in boot or beside a reset command are dropped
    assign req_live  = op_req.valid && (state_q == ST_IDLE) && !is_reset;
    assign otp_gate  = !op_req.otp || otp_en; // RULE6
    assign req_prog  = req_live && (op_req.kind == OP_PROGRAM) &&
                       wel_q && otp_gate; // RULE16
    assign req_erase = req_live && (op_req.kind == OP_ERASE) &&
                       wel_q && !op_req.otp; // RULE16
    assign req_read  = req_live && (op_req.kind == OP_READ) &&
                       otp_gate; // RULE6
    assign prog_bad  = op_req.addr_bad ||
                       (op_req.otp ? otp_lock : blk_locked); // RULE12
    assign erase_bad = blk_locked; // RULE14

    logic prog_reject;
    logic prog_go;
    logic erase_reject;
    logic erase_go;
    logic read_go;
    logic boot_go;
    logic any_go;

    assign prog_reject  = req_prog && prog_bad; // RULE5
    assign prog_go      = req_prog && !prog_bad; // RULE5
    assign erase_reject = req_erase && erase_bad; // RULE5
    assign erase_go     = req_erase && !erase_bad; // RULE5
    assign read_go      = req_read;
    assign boot_go      = (state_q == ST_BOOT); // RULE20
    assign any_go       = prog_go || erase_go || read_go || boot_go ||
                          is_reset;

    // Completion of the running operation
    logic done_take;
    logic done_prog_fail;
    logic done_erase_fail;
    logic done_read;

    assign done_take       = op_done.valid && (state_q == ST_BUSY);
    assign done_prog_fail  = done_take && op_done.fail &&
                             (cur_kind_q == OP_PROGRAM); // RULE12
    assign done_erase_fail = done_take && op_done.fail &&
                             (cur_kind_q == OP_ERASE); // RULE14
    assign done_read       = done_take && ((cur_kind_q == OP_READ) ||
                                           (cur_kind_q == OP_BOOT)); // RULE20

    // Status flags: a setting event beats a clear in the same cycle
    logic pf_set;
    logic pf_clr;
    logic ef_set;
    logic ef_clr;

    assign pf_set       = prog_reject || done_prog_fail; // RULE12
    assign pf_clr       = prog_go || is_reset; // RULE13
    assign prog_fail_d  = pf_set ? 1'b1 : (pf_clr ? 1'b0 : prog_fail_q);
    assign ef_set       = erase_reject || done_erase_fail; // RULE14
    assign ef_clr       = erase_go || is_reset; // RULE15
    assign erase_fail_d = ef_set ? 1'b1 : (ef_clr ? 1'b0 : erase_fail_q);
    assign ecc_result_d = done_read ? op_done.ecc : // RULE21
                          (read_go || is_reset) ? `ECC_NONE :
                                                  ecc_result_q; // RULE18
    assign wel_d        = is_wren ? 1'b1 :
                          (is_wrdis ? 1'b0 : wel_q); // RULE23

    // Busy follows start and done; a new start keeps it high
    assign busy_d     = any_go ? 1'b1 :
                        (done_take ? 1'b0 : busy_q); // RULE17
    assign state_d    = any_go ? ST_BUSY :
                        (done_take ? ST_IDLE : state_q);
    assign cur_kind_d = is_reset ? OP_RESET :
                        boot_go  ? OP_BOOT :
                        prog_go  ? OP_PROGRAM :
                        erase_go ? OP_ERASE :
                        read_go  ? OP_READ : cur_kind_q;

    assign op_start_d.valid  = any_go;
    assign op_start_d.kind   = cur_kind_d;
    assign op_start_d.block  = boot_go ? `BLOCK_W'(0) : op_req.block;
    assign op_start_d.otp    = (prog_go || read_go) && op_req.otp;
    assign op_start_d.ecc_on = cr_q[`CR_ECC_ENABLE]; // RULE7

    // Status byte view
    assign sr_view[7:6]           = 2'h0; // RULE24
    assign sr_view[`SR_ECC_HIGH]  = ecc_result_q[1];
    assign sr_view[`SR_ECC_LOW]   = ecc_result_q[0];
    assign sr_view[`SR_PROG_FAIL] = prog_fail_q;
    assign sr_view[`SR_ERASE_FAIL]= erase_fail_q;
    assign sr_view[`SR_WEL]       = wel_q;
    assign sr_view[`SR_BUSY]      = busy_q;

    // Unmapped feature addresses read as zero
    assign rd_data_d = !is_get ? rd_data_q :
                       addr_pr ? pr_q :
                       addr_cr ? cr_q :
                       addr_sr ? sr_view : 8'h00; // RULE11

    // Register storage; reset is the only way to lift the freeze
    always_ff @(posedge clk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            pr_q <= `PR_RESET;
            cr_q <= `CR_RESET;
        end
        else
        begin
            pr_q <= pr_d;
            cr_q <= cr_d;
        end
    end

    always_ff @(posedge clk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            busy_q       <= 1'(`SR_RESET >> `SR_BUSY);
            wel_q        <= 1'b0;
            prog_fail_q  <= 1'b0;
            erase_fail_q <= 1'b0;
            ecc_result_q <= `ECC_NONE;
        end
        else
        begin
            busy_q       <= busy_d;
            wel_q        <= wel_d;
            prog_fail_q  <= prog_fail_d;
            erase_fail_q <= erase_fail_d;
            ecc_result_q <= ecc_result_d;
        end
    end

    always_ff @(posedge clk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            state_q    <= ST_BOOT;
            cur_kind_q <= OP_BOOT;
            otp_mode_q <= OTP_NORMAL;
        end
        else
        begin
            state_q    <= state_d;
            cur_kind_q <= cur_kind_d;
            otp_mode_q <= otp_mode_d;
        end
    end

    always_ff @(posedge clk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
            op_start_q <= '0;
        end
        else
        begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= is_get;
            op_start_q <= op_start_d;
        end
    end

    assign rd_data            = rd_data_q;
    assign rd_valid           = rd_valid_q;
    assign op_start           = op_start_q;
    assign ecc_enable         = cr_q[`CR_ECC_ENABLE]; // RULE7
    assign otp_mode           = otp_mode_q;
    assign busy               = busy_q;
    assign write_enable_latch = wel_q;
    assign protect_frozen     = cr_q[`CR_FREEZE];
endmodule

`default_nettype wire

//--- testbench/feature_checker.sv
// Port assertions for the feature register bank.
// Assumes binding onto nand_feature_protect_status_regs, one clock domain.
`default_nettype none
`include "nand_feature_map.svh"
module feature_checker (
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        rst_n,
    // Bank inputs
    input wire nand_feature_pkg::feat_cmd_t cmd,
    input wire nand_feature_pkg::op_req_t   op_req,
    input wire nand_feature_pkg::op_done_t  op_done,
    // Bank outputs
    input wire logic [7:0]                  rd_data,
    input wire logic                        rd_valid,
    input wire nand_feature_pkg::op_start_t op_start,
    input wire logic                        ecc_enable,
    input wire nand_feature_pkg::otp_mode_t otp_mode,
    input wire logic                        busy,
    input wire logic                        write_enable_latch,
    input wire logic                        protect_frozen
);
    timeunit 1ns;
    timeprecision 1ps;
    import nand_feature_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence get_seen;
        cmd.valid && cmd.opcode == `OPC_GET_FEATURE;
    endsequence
    sequence wren_seen;
        cmd.valid && cmd.opcode == `OPC_WRITE_ENABLE;
    endsequence
    sequence wrdis_seen;
        cmd.valid && cmd.opcode == `OPC_WRITE_DISABLE;
    endsequence
    // Boot start is excluded; its busy rises on the same edge as the start
    sequence run_start;
        op_start.valid && op_start.kind != OP_BOOT;
    endsequence
    sequence wr_start;
        op_start.valid && op_start.kind inside {OP_PROGRAM, OP_ERASE};
    endsequence
    sequence otp_start;
        op_start.valid && op_start.otp;
    endsequence
    a_get_answer: assert property (get_seen |=> rd_valid)
        else $error("get feature not answered next cycle");
    a_wel_set: assert property (wren_seen |=> write_enable_latch)
        else $error("write enable did not set latch");
    a_wel_clear: assert property (wrdis_seen |=> !write_enable_latch)
        else $error("write disable did not clear latch");
    a_start_busy: assert property (run_start |-> busy)
        else $error("operation started without busy");
    a_start_latch: assert property (wr_start |-> $past(write_enable_latch))
        else $error("program or erase started with latch clear");
    a_otp_gate: assert property (otp_start |-> otp_mode inside
        {OTP_ACCESS, OTP_LOCKED})
        else $error("otp access started while otp disabled");
    a_ecc_steer: assert property (op_start.valid |->
        op_start.ecc_on == ecc_enable)
        else $error("ecc setting not passed to engine");
    a_busy_drop: assert property (busy && op_done.valid |=> !busy)
        else $error("busy stayed high after done");
    a_busy_hold: assert property (busy && !op_done.valid |=> busy)
        else $error("busy fell without done");
    a_freeze_sticky: assert property (protect_frozen |=> protect_frozen)
        else $error("protection freeze released");
endmodule

bind nand_feature_protect_status_regs feature_checker u_chk (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .op_req(op_req),
    .op_done(op_done), .rd_data(rd_data), .rd_valid(rd_valid),
    .op_start(op_start), .ecc_enable(ecc_enable), .otp_mode(otp_mode),
    .busy(busy), .write_enable_latch(write_enable_latch),
    .protect_frozen(protect_frozen)
);
`default_nettype wire

//--- testbench/array_engine_model.sv
// Behavioural array engine: one done for each start, after lat cycles.
// Assumes the bank keeps one operation in flight at a time.
`default_nettype none
module array_engine_model (
    // Clock
    input  wire logic                        clk,
    // Engine side of the bank
    input  wire nand_feature_pkg::op_start_t start,
    output var  nand_feature_pkg::op_done_t  done,
    // Behaviour chosen by the bench
    input  wire logic [3:0]                  lat,
    input  wire logic                        fail_set,
    input  wire logic [1:0]                  ecc_set
);
    timeunit 1ns;
    timeprecision 1ps;
    import nand_feature_pkg::*;
    logic [3:0] cnt_q = 4'h0;
    initial done = '0;
    // Idle fields inverted so stale results cannot pass for fresh ones
    always @(posedge clk)
    begin
        if (start.valid === 1'b1)
            cnt_q <= lat;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        if (start.valid !== 1'b1 && cnt_q == 4'h1)
            done <= {1'b1, fail_set, ecc_set};
        else
            done <= {1'b0, ~fail_set, ~ecc_set};
    end
endmodule
`default_nettype wire

//--- testbench/nand_feature_protect_status_regs_tb.sv
// Self-checking bench for the feature register bank and engine model.
// Assumes the engine model answers each start after lat cycles.
`default_nettype none
`include "nand_feature_map.svh"
module nand_feature_protect_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nand_feature_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    feat_cmd_t  cmd = '0;
    op_req_t    op_req = '0;
    op_done_t   op_done;
    op_start_t  op_start;
    otp_mode_t  otp_mode;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       ecc_enable;
    logic       busy;
    logic       wr_latch;
    logic       frozen;
    logic [3:0] lat = 4'h3;
    logic       efail = 1'b0;
    logic [1:0] eecc = 2'h1;
    logic [1:0] ecc_x = 2'h1;
    logic       pf_x = 1'b0;
    logic       ef_x = 1'b0;
    logic       we_x = 1'b0;
    logic [7:0] mv [4] = '{8'h00, 8'h40, 8'hC0, 8'h80};
    otp_mode_t  me [4] = '{OTP_NORMAL, OTP_ACCESS, OTP_LOCKED,
                           OTP_NOT_APPLICABLE};
    int         fail_count = 0;
    int         checks = 0;
    int         starts = 0;
    int         base;
    int         k;
    int         s;
    int         w;

    nand_feature_protect_status_regs u_dut (
        .clk(clk), .rst_n(rst_n), .cmd(cmd), .op_req(op_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .op_start(op_start),
        .op_done(op_done), .ecc_enable(ecc_enable), .otp_mode(otp_mode),
        .busy(busy), .write_enable_latch(wr_latch), .protect_frozen(frozen)
    );
    array_engine_model u_engine (
        .clk(clk), .start(op_start), .done(op_done), .lat(lat),
        .fail_set(efail), .ecc_set(eecc)
    );

    always #5 clk = ~clk;
    always @(posedge clk)
        if (op_start.valid === 1'b1)
            starts <= starts + 1;

    function automatic logic locked(input int c, input int t, input int b);
        if (c == 0)
            return 1'b0;
        if (c > 9)
            return 1'b1;
        if (t != 0)
            return b < (1 << c);
        return b >= 1024 - (1 << c);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] op, input logic [7:0] a,
                        input logic [7:0] v);
        @(posedge clk);
        cmd <= {1'b1, op, a, v};
        @(posedge clk);
        cmd.valid <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        send(`OPC_GET_FEATURE, a, 8'h00);
        #1;
        check({7'h00, rd_valid}, 8'h01);
        check(rd_data, exp);
    endtask
    task automatic rs();
        rd(`FA_STATUS, {2'h0, ecc_x, pf_x, ef_x, we_x, 1'b0});
    endtask
    // Bounded wait: a hang shows up as a later status mismatch
    task automatic wait_idle();
        repeat (2) @(posedge clk);
        #1;
        for (k = 0; k < 60 && busy !== 1'b0; k++)
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic reset_dut();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wait_idle();
    endtask
    task automatic req(input op_kind_t kd, input int b, input logic bad,
                       input logic otp, input logic wt);
        base = starts;
        @(posedge clk);
        op_req <= {1'b1, kd, b[9:0], bad, otp};
        @(posedge clk);
        op_req.valid <= 1'b0;
        if (wt)
            wait_idle();
    endtask
    task automatic erase_at(input int c, input int t, input int b);
        req(OP_ERASE, b, 1'b0, 1'b0, 1'b1);
        ef_x = locked(c, t, b);
        check(8'(starts - base), {7'h0, !ef_x});
        rs();
    endtask
    task automatic print_verdict();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #300us;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        reset_dut();
        rs();
        rd(`FA_CONFIG, `CR_RESET);
        rd(8'hD0, 8'h00);
        send(`OPC_SET_FEATURE, `FA_CONFIG, 8'h3F);
        rd(`FA_CONFIG, `CR_RESET);
        check({7'h0, frozen}, 8'h00);
        send(`OPC_SET_FEATURE, `FA_STATUS, 8'hFF);
        send(`OPC_WRITE_ENABLE, 8'h00, 8'h00);
        we_x = 1'b1;
        rs();
        // Every protect code and select, at both edges of the region
        for (s = 0; s < 32; s++)
        begin
            send(`OPC_SET_FEATURE, `FA_PROTECT, {1'b0, s[4:0], 2'h0});
            w = (s[4:1] inside {[1:9]}) ? 1 << s[4:1] : 2;
            erase_at(s[4:1], s[0], w - 1);
            erase_at(s[4:1], s[0], w);
            erase_at(s[4:1], s[0], 1023 - w);
            erase_at(s[4:1], s[0], 1024 - w);
        end
        send(`OPC_SET_FEATURE, `FA_PROTECT, 8'h4C);
        req(OP_PROGRAM, 0, 1'b0, 1'b0, 1'b1);
        pf_x = 1'b1;
        rs();
        req(OP_PROGRAM, 1023, 1'b0, 1'b0, 1'b1);
        pf_x = 1'b0;
        rs();
        req(OP_PROGRAM, 1023, 1'b1, 1'b0, 1'b1);
        pf_x = 1'b1;
        rs();
        efail <= 1'b1;
        req(OP_ERASE, 1023, 1'b0, 1'b0, 1'b1);
        ef_x = 1'b1;
        rs();
        efail <= 1'b0;
        send(`OPC_RESET, 8'h00, 8'h00);
        wait_idle();
        {pf_x, ef_x, ecc_x} = 4'h0;
        rs();
        for (s = 0; s < 4; s++)
        begin
            eecc <= s[1:0];
            req(OP_READ, 5, 1'b0, 1'b0, 1'b1);
            ecc_x = s[1:0];
            rs();
        end
        lat <= 4'hA;
        req(OP_READ, 5, 1'b0, 1'b0, 1'b0);
        rd(`FA_STATUS, {6'h0, we_x, 1'b1});
        wait_idle();
        lat <= 4'h3;
        send(`OPC_SET_FEATURE, `FA_CONFIG, 8'h00);
        rd(`FA_CONFIG, 8'h00);
        check({7'h0, ecc_enable}, 8'h00);
        send(`OPC_WRITE_DISABLE, 8'h00, 8'h00);
        we_x = 1'b0;
        req(OP_ERASE, 600, 1'b0, 1'b0, 1'b1);
        check(8'(starts - base), 8'h00);
        rs();
        for (s = 0; s < 4; s++)
        begin
            send(`OPC_SET_FEATURE, `FA_CONFIG, mv[s]);
            req(OP_READ, 7, 1'b0, 1'b1, 1'b1);
            check(8'(starts - base), {7'h0, mv[s][6]});
            check({6'h0, otp_mode}, {6'h0, me[s]});
        end
        send(`OPC_SET_FEATURE, `FA_PROTECT, 8'h81);
        send(`OPC_SET_FEATURE, `FA_CONFIG, 8'h20);
        send(`OPC_SET_FEATURE, `FA_PROTECT, 8'h7C);
        rd(`FA_PROTECT, 8'h81);
        check({7'h0, frozen}, 8'h01);
        reset_dut();
        rd(`FA_CONFIG, `CR_RESET);
        rs();
        print_verdict();
    end
endmodule
`default_nettype wire
